// file: interrupt_status_request_inservice_tb_top.sv
/*
 Self-checking testbench for the interrupt status block.
 Assumes register reads answer one cycle after the strobe.
*/
`timescale 1ns/1ns
module interrupt_status_request_inservice_tb_top
    import isr_pkg::*;
;
    logic sys_clk, reset, reg_write, reg_read, slave_mode, dma_zero_req, dma_one_req;
    logic external_irq_five, external_irq_six, serial_zero_enable, serial_one_enable;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] timer_req;
    logic [4:0] ext_irq;
    logic [6:0] serial_zero_sources, serial_one_sources;
    logic nmi_event, return_from_interrupt, dma_suspend, irq_out;
    logic [15:0] take_vector, eoi_vector, slave_ack;
    int errors = 0;
    int comparisons = 0;

    isr_core #(.NUM_EXT(5)) dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .slave_mode(slave_mode), .timer_req(timer_req),
        .ext_irq(ext_irq), .dma_zero_req(dma_zero_req), .dma_one_req(dma_one_req),
        .external_irq_five(external_irq_five), .external_irq_six(external_irq_six),
        .serial_zero_sources(serial_zero_sources), .serial_one_sources(serial_one_sources),
        .serial_zero_enable(serial_zero_enable), .serial_one_enable(serial_one_enable),
        .nmi_event(nmi_event),
        .return_from_interrupt(return_from_interrupt), .take_vector(take_vector),
        .eoi_vector(eoi_vector), .slave_ack(slave_ack), .dma_suspend(dma_suspend),
        .irq_out(irq_out));
    isr_core_model core (.sys_clk(sys_clk), .nmi_event(nmi_event),
        .return_from_interrupt(return_from_interrupt), .take_vector(take_vector),
        .eoi_vector(eoi_vector), .slave_ack(slave_ack));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end

    initial
    begin
        {reset, reg_write, reg_read, slave_mode, reg_addr, reg_wdata} = {1'b1, 27'h0};
        {timer_req, ext_irq, serial_zero_sources, serial_one_sources} = 22'h0;
        {dma_zero_req, dma_one_req, external_irq_five, external_irq_six} = 4'h0;
        {serial_zero_enable, serial_one_enable} = 2'b11;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd_chk(ISR_OFF_IN_SERVICE, 16'h0000);
        chk_bit(dma_suspend, 1'b0);
        $display("test reset done");
        ext_irq <= 5'h11;
        {dma_one_req, external_irq_five} <= 2'b11;
        for (int i = 0; i < 7; i++)
        begin
            serial_zero_sources <= 7'h01 << i;
            serial_one_sources <= 7'h40 >> i;
            timer_req <= 3'h1 << (i % 3);
            settle();
            rd_chk(ISR_OFF_REQUEST, 16'h071D);
            rd_chk(ISR_OFF_TSTAT, 16'h0001 << (i % 3));
        end
        {serial_zero_enable, serial_one_enable, timer_req} <= 5'h0;
        {dma_one_req, external_irq_five, dma_zero_req, external_irq_six} <= 4'h3;
        wr(ISR_OFF_REQUEST, 16'hFFFF);
        settle();
        rd_chk(ISR_OFF_REQUEST, 16'h011C);
        $display("test request done");
        core.pulse(0, 16'h0000);
        chk_bit(dma_suspend, 1'b1);
        rd_chk(ISR_OFF_TSTAT, 16'h8000);
        core.pulse(1, 16'h0000);
        chk_bit(dma_suspend, 1'b0);
        // software sets the flag with timers idle
        wr(ISR_OFF_TSTAT, 16'hFFFF);
        rd_chk(ISR_OFF_TSTAT, 16'h8000);
        chk_bit(dma_suspend, 1'b1);
        wr(ISR_OFF_TSTAT, 16'h0000);
        rd_chk(ISR_OFF_TSTAT, 16'h0000);
        $display("test suspend done");
        core.pulse(2, 16'h0406);
        rd_chk(ISR_OFF_IN_SERVICE, 16'h0404);
        core.pulse(3, 16'h0400);
        rd_chk(ISR_OFF_IN_SERVICE, 16'h0004);
        $display("test in-service done");
        rd_chk(ISR_OFF_IRQ_STAT, 16'h0007);
        chk_bit(irq_out, 1'b1);
        wr(ISR_OFF_IRQ_MASK, 16'h0007);
        settle();
        chk_bit(irq_out, 1'b0);
        wr(ISR_OFF_IRQ_MASK, 16'h0000);
        wr(ISR_OFF_IRQ_STAT, 16'h0007);
        settle();
        chk_bit(irq_out, 1'b0);
        rd_chk(ISR_OFF_IRQ_STAT, 16'h0000);
        $display("test interrupt done");
        {slave_mode, dma_zero_req, external_irq_six, dma_one_req} <= 4'h8;
        settle();
        // Requests latched while in master layout are acknowledged first.
        core.pulse(4, 16'h003D);
        rd_chk(ISR_OFF_REQUEST, 16'h0000);
        rd_chk(ISR_OFF_CTRL, 16'h0001);
        timer_req <= 3'h6;
        dma_zero_req <= 1'b1;
        settle();
        {timer_req, dma_zero_req} <= 4'h0;
        settle();
        rd_chk(ISR_OFF_REQUEST, 16'h0034);
        core.pulse(4, 16'h0010);
        rd_chk(ISR_OFF_REQUEST, 16'h0024);
        reset <= 1'b1;
        settle();
        reset <= 1'b0;
        rd_chk(ISR_OFF_REQUEST, 16'h0000);
        $display("test slave done");
        end_of_test();
    end
endmodule

// file: isr_core.sv
/*
 Interrupt status side: timer status with DMA suspend flag, request register
 in master and slave layouts, in-service register, and an event interrupt.
 Assumes sources, acknowledges and core events are synchronous to sys_clk.
*/
// What this block does
// - While the DMA suspend flag is one, DMA transfer activity is suspended.
// - Any non-maskable interrupt sets the flag; return from interrupt clears it.
// - Timer status low three bits show pending timers; bits 14 to 3 reserved.
// - Master request bit 0 is the OR of the three timer requests.
// - Request register is read-only; the master layout shows current request lines.
// - Master request register has no defined reset value.
// - Master bit 10 is the OR of seven serial port zero sources when enabled.
// - Master bit 9 is the OR of seven serial port one sources when enabled.
// - Master bits 8 to 4 show pending external inputs four to zero.
// - Bit 3 is DMA one or ext six, bit 2 DMA zero or ext five.
// - Slave request bits set on internal request, cleared by acknowledge.
// - Slave request register resets to zero.
// - Slave bit 5 timer 2, bit 4 timer 1, bit 0 timer 0.
// - In-service bit is set when the processor takes that source.
// - In-service resets to zero and follows the request layout of the selected mode.
// - In-service bit at one means the source is being serviced.
`timescale 1ns/1ns
module isr_core
    import isr_pkg::*;
#(
    parameter int NUM_EXT = 5
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Mode: one selects slave layout.
    input wire logic slave_mode,
    // Request sources.
    input wire logic [2:0] timer_req,
    input wire logic [NUM_EXT-1:0] ext_irq,
    input wire logic dma_zero_req,
    input wire logic dma_one_req,
    input wire logic external_irq_five,
    input wire logic external_irq_six,
    input wire logic [6:0] serial_zero_sources,
    input wire logic [6:0] serial_one_sources,
    input wire logic serial_zero_enable,
    input wire logic serial_one_enable,
    // Core events.
    input wire logic nmi_event,
    input wire logic return_from_interrupt,
    input wire logic [15:0] take_vector,
    input wire logic [15:0] eoi_vector,
    input wire logic [15:0] slave_ack,
    // Outputs.
    output logic dma_suspend,
    output logic irq_out
);
    isr_mode_t mode;
    logic dma_suspend_flag_reg, dma_suspend_flag_next;
    logic [2:0] timer_pending_reg, timer_pending_next;
    logic [15:0] req_master_reg, req_slave_reg, req_slave_next;
    logic [15:0] in_service_flags_reg, in_service_flags_next;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_flags;
    logic [2:0] irq_events;
    logic [2:0] irq_clear;
    logic [15:0] read_mux;
    logic nmi_d_reg;

    // Combines an OR of sources with its enable.
    function automatic logic gated_or(input logic [6:0] src, input logic en);
        gated_or = en & (|src);
    endfunction

    assign mode = slave_mode ? ISR_MODE_SLAVE : ISR_MODE_MASTER;
    wire hit_in_service = (reg_addr == ISR_OFF_IN_SERVICE);
    wire hit_request = (reg_addr == ISR_OFF_REQUEST);
    wire hit_tstat = (reg_addr == ISR_OFF_TSTAT);
    wire hit_stat = (reg_addr == ISR_OFF_IRQ_STAT);
    wire hit_mask = (reg_addr == ISR_OFF_IRQ_MASK);
    wire hit_ctrl = (reg_addr == ISR_OFF_CTRL);
    wire wr_tstat = reg_write & hit_tstat;
    wire wr_in_service = reg_write & hit_in_service;
    wire [15:0] layout_mask = (mode == ISR_MODE_SLAVE) ? ISR_SLAVE_MASK : ISR_MASTER_MASK;

    wire [15:0] master_req_now = {5'h00,
        gated_or(serial_zero_sources, serial_zero_enable),
        gated_or(serial_one_sources, serial_one_enable),
        ext_irq[4:0],
        dma_one_req | external_irq_six,
        dma_zero_req | external_irq_five,
        1'b0,
        |timer_req};

    wire [15:0] slave_set = {10'h000, timer_req[2], timer_req[1],
        dma_one_req | external_irq_six, dma_zero_req | external_irq_five,
        1'b0, timer_req[0]};
    assign req_slave_next = ((req_slave_reg & ~slave_ack) | slave_set) & ISR_SLAVE_MASK;

    always_comb
    begin
        dma_suspend_flag_next = dma_suspend_flag_reg;
        if (wr_tstat)
            dma_suspend_flag_next = reg_wdata[ISR_BIT_SUSPEND];
        if (return_from_interrupt)
            dma_suspend_flag_next = 1'b0;
        if (nmi_event)
            dma_suspend_flag_next = 1'b1;
    end

    assign timer_pending_next = timer_req;

    assign in_service_flags_next = ((in_service_flags_reg & ~eoi_vector
        & ~(wr_in_service ? ~reg_wdata : 16'h0000)) | take_vector) & layout_mask;

    always_comb
    begin
        read_mux = 16'h0000;
        if (hit_in_service)
            read_mux = in_service_flags_reg;
        else if (hit_request)
            read_mux = (mode == ISR_MODE_SLAVE) ? req_slave_reg : req_master_reg;
        else if (hit_tstat)
            read_mux = {dma_suspend_flag_reg, 12'h000, timer_pending_reg};
        else if (hit_stat)
            read_mux = {13'h0000, irq_flags};
        else if (hit_mask)
            read_mux = {13'h0000, irq_mask_reg};
        else if (hit_ctrl)
            read_mux = {15'h0000, slave_mode};
    end

    assign irq_events = {nmi_event & ~nmi_d_reg, return_from_interrupt, |take_vector};
    assign irq_clear = (reg_write & hit_stat) ? reg_wdata[2:0] : 3'h0;

    isr_sticky #(
        .WIDTH(3)
    ) u_sticky (
        .sys_clk(sys_clk),
        .reset(reset),
        .set_in(irq_events),
        .clr_in(irq_clear),
        .flag_out(irq_flags)
    );

    always_ff @(posedge sys_clk)
    begin
        req_master_reg <= master_req_now;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            req_slave_reg <= ISR_REQUEST_SLAVE_RST;
            in_service_flags_reg <= ISR_IN_SERVICE_RST;
            dma_suspend_flag_reg <= 1'b0;
            timer_pending_reg <= 3'h0;
            irq_mask_reg <= ISR_IRQ_MASK_RST;
            nmi_d_reg <= 1'b0;
        end
        else
        begin
            req_slave_reg <= req_slave_next;
            in_service_flags_reg <= in_service_flags_next;
            dma_suspend_flag_reg <= dma_suspend_flag_next;
            timer_pending_reg <= timer_pending_next;
            nmi_d_reg <= nmi_event;
            if (reg_write & hit_mask)
                irq_mask_reg <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            reg_rdata <= 16'h0000;
            dma_suspend <= 1'b0;
            irq_out <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_read ? read_mux : 16'h0000;
            dma_suspend <= dma_suspend_flag_next;
            irq_out <= |(irq_flags & ~irq_mask_reg);
        end
    end

    // The request and timer read checks below compare read data against the inputs two edges back:
    // one edge for the request or timer snapshot and one for the registered read port.

    AST_SUSPEND_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
        dma_suspend == dma_suspend_flag_reg)
        else $error("dma suspend does not follow flag");
    AST_NMI_SETS: assert property (@(posedge sys_clk) disable iff (reset)
        nmi_event |=> dma_suspend_flag_reg && dma_suspend)
        else $error("nmi did not set suspend flag");
    AST_RET_CLEARS: assert property (@(posedge sys_clk) disable iff (reset)
        return_from_interrupt && !nmi_event |=> !dma_suspend_flag_reg)
        else $error("return did not clear suspend flag");
    AST_SOFT_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        wr_tstat && !nmi_event && !return_from_interrupt
        |=> dma_suspend_flag_reg == $past(reg_wdata[ISR_BIT_SUSPEND]))
        else $error("software write to suspend flag lost");
    AST_TIMER_BITS: assert property (@(posedge sys_clk) disable iff (reset)
        reg_read && hit_tstat |=> reg_rdata[2:0] == $past(timer_req, 2))
        else $error("timer status bits wrong");
    AST_TIMER_SUMMARY: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && reg_read && hit_request |=> reg_rdata[0] == |$past(timer_req, 2))
        else $error("timer summary wrong");
    AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (reset)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data present without a read");
    AST_SERIAL_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && reg_read && hit_request |=> reg_rdata[ISR_BIT_SERIAL_ZERO]
        == ($past(serial_zero_enable, 2) && (|$past(serial_zero_sources, 2))))
        else $error("serial port zero request bit wrong");
    AST_SERIAL_ONE: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && reg_read && hit_request |=> reg_rdata[ISR_BIT_SERIAL_ONE]
        == ($past(serial_one_enable, 2) && (|$past(serial_one_sources, 2))))
        else $error("serial port one request bit wrong");
    AST_EXT_BITS: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && reg_read && hit_request |=> reg_rdata[8:4] == $past(ext_irq[4:0], 2))
        else $error("external request bits wrong");
    AST_DMA_ONE_PAIR: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && reg_read && hit_request |=> reg_rdata[ISR_BIT_DMA_ONE]
        == ($past(dma_one_req, 2) || $past(external_irq_six, 2)))
        else $error("dma one pair bit wrong");
    AST_DMA_ZERO_PAIR: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && reg_read && hit_request |=> reg_rdata[ISR_BIT_DMA_ZERO]
        == ($past(dma_zero_req, 2) || $past(external_irq_five, 2)))
        else $error("dma zero pair bit wrong");
    AST_SLAVE_ACK: assert property (@(posedge sys_clk) disable iff (reset)
        slave_ack[0] && !timer_req[0] |=> !req_slave_reg[0])
        else $error("slave ack did not clear");
    AST_SLAVE_RESET: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(reset) |-> req_slave_reg == ISR_REQUEST_SLAVE_RST)
        else $error("slave request not zero after reset");
    AST_SLAVE_T2: assert property (@(posedge sys_clk) disable iff (reset)
        timer_req[2] |=> req_slave_reg[ISR_BIT_SLAVE_TIMER_TWO])
        else $error("slave timer two not set");
    AST_SLAVE_T1: assert property (@(posedge sys_clk) disable iff (reset)
        timer_req[1] |=> req_slave_reg[ISR_BIT_SLAVE_TIMER_ONE])
        else $error("slave timer one not set");
    AST_SLAVE_T0: assert property (@(posedge sys_clk) disable iff (reset)
        timer_req[0] |=> req_slave_reg[ISR_BIT_TIMER_SUM])
        else $error("slave timer zero not set");
    AST_SLAVE_LAYOUT: assert property (@(posedge sys_clk) disable iff (reset)
        slave_mode && reg_read && hit_request |=> reg_rdata[15:6] == 10'h000)
        else $error("slave request reserved bits nonzero");
    AST_TAKE_SETS: assert property (@(posedge sys_clk) disable iff (reset)
        !slave_mode && take_vector[ISR_BIT_SERIAL_ZERO]
        |=> in_service_flags_reg[ISR_BIT_SERIAL_ZERO])
        else $error("in-service not set on take");
    AST_SERVICE_RESET: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(reset) |-> in_service_flags_reg == ISR_IN_SERVICE_RST)
        else $error("in-service not zero after reset");
    AST_SERVICE_END: assert property (@(posedge sys_clk) disable iff (reset)
        eoi_vector[ISR_BIT_DMA_ZERO] && !take_vector[ISR_BIT_DMA_ZERO]
        |=> !in_service_flags_reg[ISR_BIT_DMA_ZERO])
        else $error("in-service bit held after end of service");
    AST_RESERVED: assert property (@(posedge sys_clk) disable iff (reset)
        reg_read && hit_tstat |=> reg_rdata[14:3] == 12'h000)
        else $error("reserved bits nonzero");
    AST_REQ_RESERVED: assert property (@(posedge sys_clk) disable iff (reset)
        reg_read && hit_request |=> reg_rdata[15:11] == 5'h00)
        else $error("request reserved bits nonzero");

    // Covers for the main scenarios: suspend cycle, interrupt, slave, service.
    COV_NMI: cover property (@(posedge sys_clk) disable iff (reset)
        nmi_event ##[1:20] return_from_interrupt);
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (reset) irq_out);
    COV_SLAVE: cover property (@(posedge sys_clk) disable iff (reset)
        slave_mode && req_slave_reg[ISR_BIT_DMA_ONE]);
    COV_SERVICE: cover property (@(posedge sys_clk) disable iff (reset)
        in_service_flags_reg[ISR_BIT_SERIAL_ZERO] ##[1:20] eoi_vector[ISR_BIT_SERIAL_ZERO]);
    COV_SERIAL: cover property (@(posedge sys_clk) disable iff (reset)
        req_master_reg[ISR_BIT_SERIAL_ZERO] && req_master_reg[ISR_BIT_SERIAL_ONE]);
endmodule

// file: isr_core_model.sv
/*
 Model of the processor core side: non-maskable event, return, take,
 end-of-interrupt and slave acknowledge pulses.
 Assumes one system clock; callers wait for a task to return.
*/
`timescale 1ns/1ns
module isr_core_model (
    // Clock.
    input wire logic sys_clk,
    // Core events.
    output logic nmi_event,
    output logic return_from_interrupt,
    output logic [15:0] take_vector,
    output logic [15:0] eoi_vector,
    output logic [15:0] slave_ack
);
    initial
    begin
        nmi_event = 1'b0;
        return_from_interrupt = 1'b0;
        take_vector = 16'h0000;
        eoi_vector = 16'h0000;
        slave_ack = 16'h0000;
    end

    // Every core event is a single-cycle pulse.
    task automatic pulse(input int kind, input logic [15:0] vec);
        @(posedge sys_clk);
        nmi_event <= (kind == 0);
        return_from_interrupt <= (kind == 1);
        take_vector <= (kind == 2) ? vec : 16'h0000;
        eoi_vector <= (kind == 3) ? vec : 16'h0000;
        slave_ack <= (kind == 4) ? vec : 16'h0000;
        @(posedge sys_clk);
        nmi_event <= 1'b0;
        return_from_interrupt <= 1'b0;
        take_vector <= 16'h0000;
        eoi_vector <= 16'h0000;
        slave_ack <= 16'h0000;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

// file: isr_pkg.sv
/*
 Package for the interrupt status, request and in-service block.
 Holds register offsets, field positions, reset values and the bus layout.
 Assumes a 16-bit register bus addressed by byte offsets.
*/
package isr_pkg;
    localparam logic [7:0] ISR_OFF_IN_SERVICE = 8'h2C;
    localparam logic [7:0] ISR_OFF_REQUEST = 8'h2E;
    localparam logic [7:0] ISR_OFF_TSTAT = 8'h30;
    localparam logic [7:0] ISR_OFF_IRQ_STAT = 8'h40;
    localparam logic [7:0] ISR_OFF_IRQ_MASK = 8'h42;
    localparam logic [7:0] ISR_OFF_CTRL = 8'h44;
    localparam int ISR_BIT_SUSPEND = 15;
    localparam int ISR_BIT_SERIAL_ZERO = 10;
    localparam int ISR_BIT_SERIAL_ONE = 9;
    localparam int ISR_BIT_EXT_LO = 4;
    localparam int ISR_BIT_DMA_ONE = 3;
    localparam int ISR_BIT_DMA_ZERO = 2;
    localparam int ISR_BIT_TIMER_SUM = 0;
    localparam int ISR_BIT_SLAVE_TIMER_TWO = 5;
    localparam int ISR_BIT_SLAVE_TIMER_ONE = 4;
    localparam logic [15:0] ISR_MASTER_MASK = 16'h07FD;
    localparam logic [15:0] ISR_SLAVE_MASK = 16'h003D;
    localparam logic [15:0] ISR_IN_SERVICE_RST = 16'h0000;
    localparam logic [15:0] ISR_REQUEST_SLAVE_RST = 16'h0000;
    localparam logic [2:0] ISR_IRQ_MASK_RST = 3'h0;
    typedef enum logic [1:0] {
        ISR_MODE_MASTER = 2'b01,
        ISR_MODE_SLAVE = 2'b10
    } isr_mode_t;
endpackage

// file: isr_sticky.sv
/*
 Sticky event flag bank with write-one-to-clear; set wins over clear.
 Assumes set and clear pulses are synchronous to the system clock.
*/
`timescale 1ns/1ns
module isr_sticky #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Events and clears.
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    // Flags.
    output logic [WIDTH-1:0] flag_out
);
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            flag_out <= '0;
        else
            flag_out <= set_in | (flag_out & ~clr_in);
    end
endmodule
